// ==== common/event_aggregator_map.vh ====
// constants for the event aggregator: widths, counts and routing codes
`ifndef EVENT_AGGREGATOR_MAP_VH
`define EVENT_AGGREGATOR_MAP_VH

`define EA_EVT_W        8
`define EA_NUM_IRQ      16
`define EA_IRQ_W        4
`define EA_CNT_W        8
`define EA_CNT_MAX      8'hFF
`define EA_CNT_ZERO     8'h00
`define EA_DEST_W       2
`define EA_DEST_NONE    2'h0
`define EA_DEST_STATUS  2'h1
`define EA_DEST_MCAST   2'h2
`define EA_DEST_COUNT   2'h3
`define EA_STATUS_RST   16'h0000

`endif

// ==== hw/event_stage_slot.v ====
// one-entry output holding slot; a load wins over a take in the same cycle
`timescale 1ns/1ps
`include "event_aggregator_map.vh"
module event_stage_slot (
  input  wire                   sys_clk,   // clock
  input  wire                   srst,      // sync reset
  input  wire                   load,      // stage produces an event
  input  wire [`EA_EVT_W-1:0]   load_evt,  // event id produced
  input  wire [`EA_DEST_W-1:0]  load_dst,  // destination of event
  input  wire                   take,      // destination accepted it
  output reg                    full_q,    // slot holds an event
  output reg  [`EA_EVT_W-1:0]   evt_q,     // held event id
  output reg  [`EA_DEST_W-1:0]  dst_q      // held destination
);
  always @(posedge sys_clk) begin
    if (srst) begin
      full_q <= 1'b0;
      evt_q  <= {`EA_EVT_W{1'b0}};
      dst_q  <= `EA_DEST_NONE;
    end else if (load) begin
      full_q <= 1'b1;
      evt_q  <= load_evt;
      dst_q  <= load_dst;
    end else if (take) begin
      full_q <= 1'b0;
    end
  end
endmodule // event_stage_slot

// ==== hw/event_aggregator.v ====
// event aggregator: status, multicast, counted and unmapped stages
// Summary of operation
// - each status-stage event sets a status bit driving a level interrupt
// - multicast stage splits one accepted event into up to two events
// - counted stage emits event only on zero/non-zero count transitions
// - multicast and counted outputs are new events routed by mapping
// - a stage with a blocked output accepts no new input
// - unmapped stage maps fixed-destination events to programmed destinations
// - multicast, counted, unmapped stages may set status bits directly
// - routing multicast or counted events to status stage still works
`timescale 1ns/1ps
`include "event_aggregator_map.vh"
module event_aggregator (
  input  wire                    sys_clk,        // 10 MHz clock
  input  wire                    srst,           // sync reset, high
  input  wire                    lane_valid,     // incoming event on transport lane
  input  wire [`EA_EVT_W-1:0]    lane_evt,       // incoming event id
  input  wire [`EA_DEST_W-1:0]   lane_dst,       // incoming stage select
  input  wire                    lane_unmapped,  // event sent to fixed destination
  output reg                     lane_ready_q,   // lane input may be offered
  output reg                     out_valid_q,    // outgoing lane event
  output reg  [`EA_EVT_W-1:0]    out_evt_q,      // outgoing event id
  input  wire                    out_ready,      // outside accepts outgoing
  input  wire                    count_dec,      // consumer drains one count
  input  wire [`EA_DEST_W-1:0]   mc_dst_a,       // multicast map, first copy
  input  wire [`EA_DEST_W-1:0]   mc_dst_b,       // multicast map, second copy
  input  wire                    mc_two,         // multicast emits second copy
  input  wire [`EA_DEST_W-1:0]   cnt_dst,        // counted map destination
  input  wire [`EA_DEST_W-1:0]   um_dst,         // unmapped map destination
  input  wire                    mc_direct,      // multicast sets status directly
  input  wire                    cnt_direct,     // counted sets status directly
  input  wire                    um_direct,      // unmapped sets status directly
  input  wire [`EA_NUM_IRQ-1:0]  status_clr,     // software clear per bit
  output reg  [`EA_NUM_IRQ-1:0]  irq_q,          // level interrupts
  output reg  [`EA_CNT_W-1:0]    count_q         // counted stage value
);
  // ****************************************
  // helpers
  // ****************************************
  function [`EA_NUM_IRQ-1:0] bit_of;
    input [`EA_EVT_W-1:0] e;
    begin
      bit_of = {{(`EA_NUM_IRQ-1){1'b0}}, 1'b1} << e[`EA_IRQ_W-1:0];
    end
  endfunction

  // ****************************************
  // holding slots
  // ****************************************
  wire                  mc_full;
  wire [`EA_EVT_W-1:0]  mc_evt;
  wire [`EA_DEST_W-1:0] mc_dst;
  wire                  ct_full;
  wire [`EA_EVT_W-1:0]  ct_evt;
  wire [`EA_DEST_W-1:0] ct_dst;
  reg                   mc_load;
  reg  [`EA_EVT_W-1:0]  mc_load_evt;
  reg  [`EA_DEST_W-1:0] mc_load_dst;
  reg                   ct_load;
  reg  [`EA_DEST_W-1:0] ct_load_dst;
  reg                   mc_take;
  reg                   ct_take;
  reg                   mc_second_q;
  reg  [`EA_EVT_W-1:0]  mc_cur_q;

  event_stage_slot u_mc_slot (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .load     (mc_load),
    .load_evt (mc_load_evt),
    .load_dst (mc_load_dst),
    .take     (mc_take),
    .full_q   (mc_full),
    .evt_q    (mc_evt),
    .dst_q    (mc_dst)
  );

  event_stage_slot u_ct_slot (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .load     (ct_load),
    .load_evt (`EA_EVT_W'h00),
    .load_dst (ct_load_dst),
    .take     (ct_take),
    .full_q   (ct_full),
    .evt_q    (ct_evt),
    .dst_q    (ct_dst)
  );

  // ****************************************
  // input acceptance and routing
  // ****************************************
  wire in_take = lane_valid && lane_ready_q;
  wire [`EA_DEST_W-1:0] in_dst = lane_unmapped ? um_dst : lane_dst;
  // internal hop from multicast slot into counted stage
  wire mc_to_ct = mc_full && (mc_dst == `EA_DEST_COUNT) && !ct_full;
  // counted slot never feeds multicast; such a mapping is dropped
  wire ct_to_mc = ct_full && (ct_dst == `EA_DEST_MCAST);
  wire out_free = !out_valid_q || out_ready;

  reg [`EA_NUM_IRQ-1:0] set_v;
  reg                   out_load;
  reg [`EA_EVT_W-1:0]   out_load_evt;
  reg                   cnt_inc;
  reg                   cnt_evt;

  always @* begin
    set_v        = {`EA_NUM_IRQ{1'b0}};
    mc_load      = 1'b0;
    mc_load_evt  = lane_evt;
    mc_load_dst  = mc_dst_a;
    mc_take      = 1'b0;
    ct_take      = 1'b0;
    cnt_inc      = 1'b0;
    out_load     = 1'b0;
    out_load_evt = lane_evt;
    // drain counted slot first so it wins the output over the multicast slot
    if (ct_full) begin
      if (ct_to_mc) begin
        ct_take = 1'b1;
      end else if (ct_dst == `EA_DEST_STATUS) begin
        set_v   = set_v | bit_of(ct_evt);
        ct_take = 1'b1;
      end else if (out_free) begin
        out_load     = 1'b1;
        out_load_evt = ct_evt;
        ct_take      = 1'b1;
      end
    end
    // drain multicast slot
    if (mc_full) begin
      if (mc_dst == `EA_DEST_STATUS) begin
        set_v   = set_v | bit_of(mc_evt);
        mc_take = 1'b1;
      end else if (mc_to_ct) begin
        cnt_inc = 1'b1;
        mc_take = 1'b1;
      end else if (mc_dst != `EA_DEST_COUNT && !out_load && out_free) begin
        out_load     = 1'b1;
        out_load_evt = mc_evt;
        mc_take      = 1'b1;
      end
      if (mc_take && mc_second_q) begin
        mc_load     = 1'b1;
        mc_load_evt = mc_cur_q;
        mc_load_dst = mc_dst_b;
      end
    end
    // accept new lane event
    if (in_take) begin
      case (in_dst)
        `EA_DEST_STATUS: set_v = set_v | bit_of(lane_evt);
        `EA_DEST_MCAST: begin
          if (mc_direct) begin
            set_v = set_v | bit_of(lane_evt);
          end
          mc_load     = 1'b1;
          mc_load_evt = lane_evt;
          mc_load_dst = mc_dst_a;
        end
        `EA_DEST_COUNT: cnt_inc = 1'b1;
        default: begin
          if (lane_unmapped && um_direct) begin
            set_v = set_v | bit_of(lane_evt);
          end
        end
      endcase
    end
  end

  // ****************************************
  // counted stage
  // ****************************************
  wire dec_ok = count_dec && (count_q != `EA_CNT_ZERO);
  wire inc_ok = cnt_inc && (count_q != `EA_CNT_MAX);
  wire [`EA_CNT_W-1:0] count_d = inc_ok && !dec_ok ? count_q + 8'h01 :
                                 dec_ok && !inc_ok ? count_q - 8'h01 : count_q;
  always @* begin
    cnt_evt = (count_q == `EA_CNT_ZERO) != (count_d == `EA_CNT_ZERO);
  end
  always @* begin
    ct_load     = cnt_evt && !cnt_direct;
    ct_load_dst = cnt_dst;
  end

  // ****************************************
  // registers
  // ****************************************
  always @(posedge sys_clk) begin
    if (srst) begin
      lane_ready_q <= 1'b0;
      out_valid_q  <= 1'b0;
      out_evt_q    <= {`EA_EVT_W{1'b0}};
      irq_q        <= `EA_STATUS_RST;
      count_q      <= `EA_CNT_ZERO;
      mc_second_q  <= 1'b0;
      mc_cur_q     <= {`EA_EVT_W{1'b0}};
    end else begin
      // set wins over clear
      irq_q <= (irq_q & ~status_clr) | set_v |
               ((cnt_evt && cnt_direct) ? bit_of(ct_evt) : {`EA_NUM_IRQ{1'b0}});
      count_q <= count_d;
      if (out_load) begin
        out_valid_q <= 1'b1;
        out_evt_q   <= out_load_evt;
      end else if (out_ready) begin
        out_valid_q <= 1'b0;
      end
      if (in_take && in_dst == `EA_DEST_MCAST) begin
        mc_second_q <= mc_two;
        mc_cur_q    <= lane_evt;
      end else if (mc_take && mc_second_q) begin
        mc_second_q <= 1'b0;
      end
      // stall input while any stage output stays pending
      lane_ready_q <= !(mc_full && !mc_take) && !mc_load &&
                      !(ct_full && !ct_take) && !ct_load;
    end
  end
endmodule // event_aggregator

// ==== test/event_aggregator_assertions.sv ====
// checker: port timing properties of the event aggregator
`timescale 1ns/1ps
`include "event_aggregator_map.vh"
module event_aggregator_assertions (
  input logic        sys_clk,       // clock
  input logic        srst,          // reset
  input logic        lane_valid,    // offered
  input logic [7:0]  lane_evt,      // event id
  input logic [1:0]  lane_dst,      // stage
  input logic        lane_unmapped, // fixed dest
  input logic        lane_ready_q,  // ready
  input logic        out_valid_q,   // out valid
  input logic        out_ready,     // out accept
  input logic        count_dec,     // drain
  input logic [15:0] status_clr,    // clear
  input logic [15:0] irq_q,         // irqs
  input logic [7:0]  count_q        // count
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire take = lane_valid & lane_ready_q & ~lane_unmapped;
  wire cin  = take & (lane_dst == `EA_DEST_COUNT);
  wire sin  = take & (lane_dst == `EA_DEST_STATUS);
  wire idle = lane_ready_q & ~lane_valid;
  status_set_a: assert property (sin |=> irq_q[$past(lane_evt[3:0])])
    else $error("status bit not set");
  status_hold_a: assert property (1 |=>
    ($past(irq_q) & ~$past(status_clr) & ~irq_q) == 16'h0000) else $error("status bit lost");
  out_hold_a: assert property (out_valid_q && !out_ready |=> out_valid_q)
    else $error("out event dropped");
  blocked_stall_a: assert property (take && lane_dst == 2'h2 |=> !lane_ready_q)
    else $error("ready while split pending");
  count_up_a: assert property (cin && !count_dec && count_q != 8'hff |=>
    count_q == $past(count_q) + 8'h01) else $error("count not raised");
  count_sat_a: assert property (idle && !count_dec && count_q == 8'hff |=>
    count_q == 8'hff) else $error("count wrapped");
  count_down_a: assert property (idle && count_dec && count_q != 8'h00 |=>
    count_q == $past(count_q) - 8'h01) else $error("count not lowered");
  count_zero_a: assert property (idle && count_q == 8'h00 |=> count_q == 8'h00)
    else $error("count left zero");
  cover property (sin);
  cover property (cin);
  cover property (count_dec && count_q != 8'h00);
  cover property (out_valid_q && out_ready);
endmodule // event_aggregator_assertions
bind event_aggregator event_aggregator_assertions chk_i (.sys_clk, .srst, .lane_valid,
  .lane_evt, .lane_dst, .lane_unmapped, .lane_ready_q, .out_valid_q, .out_ready, .count_dec,
  .status_clr, .irq_q, .count_q);

// ==== test/event_sink.sv ====
// far-side sink taking outgoing events after a stall
`timescale 1ns/1ps
module event_sink #(parameter int STALL = 2) (
  input  logic sys_clk,     // clock
  input  logic srst,        // reset
  input  logic out_valid_q, // offered
  output logic out_ready    // accepted
);
  int n_q;
  always @(posedge sys_clk) begin
    if (srst || !out_valid_q || out_ready) begin
      out_ready <= 1'b0;
      n_q <= 0;
    end else begin
      n_q <= n_q + 1;
      out_ready <= (n_q >= STALL);
    end
  end
endmodule // event_sink

// ==== test/event_aggregator_tb_top.sv ====
// testbench: directed scenarios for the event aggregator
`timescale 1ns/1ps
`include "event_aggregator_map.vh"
module event_aggregator_tb_top;
  logic sys_clk = '0, srst = 1'b1, lane_valid = '0, lane_unmapped = '0, count_dec = '0;
  logic mc_two = '0, mc_direct = '0, cnt_direct = '0, um_direct = '0;
  logic [7:0] lane_evt = '0;
  logic [1:0] lane_dst = '0, mc_dst_a = '0, mc_dst_b = '0, cnt_dst = '0, um_dst = '0;
  logic [15:0] status_clr = '0;
  wire lane_ready_q, out_valid_q, out_ready;
  wire [7:0] out_evt_q, count_q;
  wire [15:0] irq_q;
  int miscompares = 0, cmp_count = 0;
  initial forever #50 sys_clk = ~sys_clk;
  event_aggregator uut (.sys_clk, .srst, .lane_valid, .lane_evt, .lane_dst, .lane_unmapped,
    .lane_ready_q, .out_valid_q, .out_evt_q, .out_ready, .count_dec, .mc_dst_a, .mc_dst_b,
    .mc_two, .cnt_dst, .um_dst, .mc_direct, .cnt_direct, .um_direct, .status_clr, .irq_q,
    .count_q);
  event_sink #(.STALL(2)) sink (.sys_clk, .srst, .out_valid_q, .out_ready);
  task end_of_test;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input bit ok, input string m);
    cmp_count++;
    if (!ok) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task tick(input int n);
    lane_valid <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask
  task send(input logic [1:0] d, input logic [7:0] e, input logic u);
    int n;
    n = 0;
    lane_valid <= 1'b1;
    lane_dst <= d;
    lane_evt <= e;
    lane_unmapped <= u;
    do begin
      @(posedge sys_clk);
      n++;
    end while (lane_ready_q !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk(1'b0, "lane stuck");
      end_of_test;
    end
  endtask
  task wait_irq(input int b);
    int n;
    n = 0;
    lane_valid <= 1'b0;
    while (irq_q[b] !== 1'b1 && n < 10) begin
      @(posedge sys_clk);
      n++;
    end
    chk(irq_q[b] === 1'b1, "irq missing");
    if (n >= 10) end_of_test;
  endtask
  task clear_all;
    status_clr <= 16'hffff;
    tick(1);
    status_clr <= '0;
    tick(1);
  endtask
  task t_status;
    send(2'h1, 8'h03, 1'b0);
    send(2'h1, 8'h1c, 1'b0);
    tick(1);
    chk(irq_q === 16'h1008, "status set");
    tick(6);
    chk(irq_q === 16'h1008, "status held");
    clear_all;
    chk(irq_q === 16'h0000, "status clear");
    um_dst <= 2'h1;
    send(2'h0, 8'h05, 1'b1);
    tick(1);
    chk(irq_q === 16'h0020, "unmapped");
    clear_all;
  endtask
  task t_count;
    cnt_dst <= 2'h1;
    repeat (3) send(2'h3, 8'h00, 1'b0);
    wait_irq(0);
    tick(1);
    chk(count_q === 8'h03, "count");
    clear_all;
    tick(2);
    chk(irq_q === 16'h0000, "no event");
    count_dec <= 1'b1;
    tick(3);
    count_dec <= 1'b0;
    tick(1);
    chk(count_q === 8'h00, "drained");
    wait_irq(0);
    clear_all;
  endtask
  task t_mcast;
    mc_dst_a <= 2'h1;
    mc_dst_b <= 2'h3;
    mc_two <= 1'b1;
    send(2'h2, 8'h07, 1'b0);
    tick(1);
    chk(lane_ready_q === 1'b0, "ready while split");
    wait_irq(7);
    tick(4);
    chk(count_q === 8'h01, "copy b");
    chk(irq_q === 16'h0081, "copy a");
    clear_all;
  endtask
  task t_saturate;
    cnt_dst <= 2'h0;
    repeat (256) send(2'h3, 8'h00, 1'b0);
    tick(1);
    chk(count_q === 8'hff, "saturate");
    srst <= 1'b1;
    tick(1);
    srst <= 1'b0;
    tick(2);
    chk(count_q === 8'h00 && irq_q === 16'h0000, "second reset");
  endtask
  task t_out;
    mc_dst_a <= 2'h0;
    mc_two <= 1'b0;
    send(2'h2, 8'h5a, 1'b0);
    tick(2);
    chk(out_valid_q === 1'b1 && out_evt_q === 8'h5a, "out event");
    tick(2);
    chk(out_valid_q === 1'b1, "out held");
    tick(2);
    chk(out_valid_q === 1'b0, "out taken");
  endtask
  task t_direct;
    um_dst <= 2'h0;
    um_direct <= 1'b1;
    mc_direct <= 1'b1;
    cnt_direct <= 1'b1;
    send(2'h0, 8'h09, 1'b1);
    send(2'h2, 8'h0b, 1'b0);
    send(2'h3, 8'h00, 1'b0);
    tick(1);
    chk(irq_q === 16'h0a01, "direct set");
    chk(count_q === 8'h01, "direct count");
    um_direct <= 1'b0;
    mc_direct <= 1'b0;
    cnt_direct <= 1'b0;
    tick(6);
    clear_all;
  endtask
  initial begin
    tick(5);
    srst <= 1'b0;
    tick(2);
    chk(irq_q === 16'h0000 && count_q === 8'h00 && out_valid_q === 1'b0, "reset");
    chk(lane_ready_q === 1'b1, "ready after reset");
    t_status;
    t_count;
    t_mcast;
    t_saturate;
    t_out;
    t_direct;
    end_of_test;
  end
endmodule // event_aggregator_tb_top
